/* hdl/pcr_pkg.sv */
// Package for the PWM cycle length and reload block: register map, field
// positions, reset values and the state record.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
`default_nettype none
package pcr_pkg;
	localparam int NUM_CH = 3;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
	localparam int BASE_LEN = 8;

	// Byte addresses, one aligned word each
	localparam logic [7:0] ADR_CFG = 8'h00;
	localparam logic [7:0] ADR_CTRL = 8'h04;
	localparam logic [7:0] ADR_CNT = 8'h08;
	localparam logic [7:0] ADR_ISTAT = 8'h0C;
	localparam logic [7:0] ADR_ICLR = 8'h10;
	localparam logic [7:0] ADR_IEN = 8'h14;
	localparam logic [7:0] ADR_CH0 = 8'h20;
	localparam logic [7:0] ADR_CH_STEP = 8'h04;

	// pwm_cycle_config fields
	localparam int CFG_VIEW = 7;
	localparam int CFG_OVIE = 6;
	localparam int CFG_OVF = 5;
	localparam int CFG_UNUSED = 4;
	localparam int CFG_WRLD = 3;
	localparam int CFG_LEN_LO = 0;
	localparam int LEN_W = 3;
	localparam logic [7:0] CFG_RESET = 8'h00;

	// Control fields
	localparam int CTRL_RUN = 0;
	localparam int CTRL_WIDE_LO = 4;

	// Interrupt status / clear / enable layout
	localparam int IRQ_OVF = 0;
	localparam int IRQ_CTR = 1;
	localparam int IRQ_W = 2;

	localparam logic [CNT_W-1:0] CMP_RESET = 16'h0000;

	typedef enum logic [1:0] {
		PCR_IDLE = 2'b01,
		PCR_ACK = 2'b10
	} pcr_bus_t;

	typedef struct packed {
		logic view;
		logic ovie;
		logic ovf;
		logic wrld;
		logic [LEN_W-1:0] len;
	} pcr_cfg_t;

	typedef struct packed {
		pcr_cfg_t cfg;
		logic run;
		logic [NUM_CH-1:0] wide;
		logic [CNT_W-1:0] cnt;
		logic [NUM_CH-1:0][CNT_W-1:0] cmp;
		logic [NUM_CH-1:0][CNT_W-1:0] rld;
		logic ctr_ovf;
		logic ctr_ien;
		pcr_bus_t bus;
		logic ack;
		logic [31:0] dat;
		logic irq;
		logic [NUM_CH-1:0] pwm;
	} pcr_state_t;
endpackage
`default_nettype wire

/* hdl/pcr_top.sv */
// PWM cycle length, cycle overflow flag and 16-bit auto-reload logic,
// with the main array counter and the channel compare registers.
// Assumes a classic Wishbone master on the system clock; reset synchronous.
// Behaviour
// (R1) The cycle overflow flag requests an interrupt only while its enable is 1.
// (R2) The cycle overflow flag is set when the selected bit n of the main counter overflows.
// (R3) The cycle overflow flag is sticky: hardware or software sets it, only software clears it.
// (R4) Bit 4 of the configuration register reads 0 and ignores writes.
// (R5) With wide reload enabled, each main counter overflow copies reload into compare.
// (R6) The wide reload acts on all 16-bit channels together and on no others.
// (R7) With wide reload disabled (its reset value) compare changes only by writes.
// (R8) The cycle length select gives a cycle of code plus 8 bits for non-16-bit channels.
// (R9) Channels in 16-bit mode ignore the cycle length and use the full counter.
// (R10) With the view select at 1 the compare addresses reach the reload registers.
// (R11) A hardware set of the cycle overflow flag beats a software clear in the same cycle.
`default_nettype none
module pcr_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	output logic [pcr_pkg::NUM_CH-1:0] pwm_o
);
	pcr_pkg::pcr_state_t s_r;
	pcr_pkg::pcr_state_t s_nxt;

	logic req;
	logic cfg_wr;
	logic clr_wr;
	logic sw_ovf_clr;
	logic sw_ovf_set;
	logic cyc_wrap;
	logic ctr_wrap;
	logic [pcr_pkg::CNT_W-1:0] len_mask;
	logic [pcr_pkg::NUM_CH-1:0] ch_wr;
	logic [pcr_pkg::NUM_CH-1:0] ch_rld;
	logic [31:0] rd_word;

	// Mask of the low (code + 8) counter bits
	function automatic logic [pcr_pkg::CNT_W-1:0] cycle_mask(
		input logic [pcr_pkg::LEN_W-1:0] code);
		logic [4:0] len;
		len = 5'(code) + 5'(pcr_pkg::BASE_LEN);
		cycle_mask = pcr_pkg::CNT_W'((17'h00001 << len) - 17'h00001);
	endfunction

	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction

	// Channel index hit for a byte address
	function automatic logic ch_hit(input logic [7:0] adr, input int k);
		ch_hit = (adr == 8'(pcr_pkg::ADR_CH0 + 8'(k) * pcr_pkg::ADR_CH_STEP));
	endfunction

	always_comb begin
		// Writes are taken in the request cycle; ack follows one edge later
		req = wb_cyc_i && wb_stb_i && (s_r.bus == pcr_pkg::PCR_IDLE);
		cfg_wr = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == pcr_pkg::ADR_CFG);
		clr_wr = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == pcr_pkg::ADR_ICLR);
		sw_ovf_set = cfg_wr && wb_dat_i[pcr_pkg::CFG_OVF]; // see (R3)
		sw_ovf_clr = (cfg_wr && !wb_dat_i[pcr_pkg::CFG_OVF]) ||
			(clr_wr && wb_dat_i[pcr_pkg::IRQ_OVF]);
		len_mask = cycle_mask(s_r.cfg.len); // see (R8)
		cyc_wrap = s_r.run && ((s_r.cnt & len_mask) == len_mask); // see (R2)
		ctr_wrap = s_r.run && (s_r.cnt == pcr_pkg::CNT_MAX);
		for (int k = 0; k < pcr_pkg::NUM_CH; k++) begin
			ch_wr[k] = req && wb_we_i && ch_hit(wb_adr_i, k);
			// One enable serves every 16-bit channel at the same wrap
			ch_rld[k] = ctr_wrap && s_r.cfg.wrld && s_r.wide[k]; // see (R5) see (R6) see (R7)
		end
	end

	// Read mux; addresses outside the map read as zero
	always_comb begin
		rd_word = 32'h00000000;
		case (wb_adr_i)
			pcr_pkg::ADR_CFG: begin
				rd_word[pcr_pkg::CFG_VIEW] = s_r.cfg.view;
				rd_word[pcr_pkg::CFG_OVIE] = s_r.cfg.ovie;
				rd_word[pcr_pkg::CFG_OVF] = s_r.cfg.ovf;
				rd_word[pcr_pkg::CFG_UNUSED] = 1'b0; // see (R4)
				rd_word[pcr_pkg::CFG_WRLD] = s_r.cfg.wrld;
				rd_word[pcr_pkg::CFG_LEN_LO +: pcr_pkg::LEN_W] = s_r.cfg.len;
			end
			pcr_pkg::ADR_CTRL: begin
				rd_word[pcr_pkg::CTRL_RUN] = s_r.run;
				rd_word[pcr_pkg::CTRL_WIDE_LO +: pcr_pkg::NUM_CH] = s_r.wide;
			end
			pcr_pkg::ADR_CNT: begin
				rd_word[15:0] = s_r.cnt;
			end
			pcr_pkg::ADR_ISTAT: begin
				rd_word[pcr_pkg::IRQ_OVF] = s_r.cfg.ovf;
				rd_word[pcr_pkg::IRQ_CTR] = s_r.ctr_ovf;
			end
			pcr_pkg::ADR_IEN: begin
				rd_word[pcr_pkg::IRQ_OVF] = s_r.cfg.ovie;
				rd_word[pcr_pkg::IRQ_CTR] = s_r.ctr_ien;
			end
			default: begin
				for (int k = 0; k < pcr_pkg::NUM_CH; k++) begin
					if (ch_hit(wb_adr_i, k)) begin
						rd_word[15:0] = s_r.cfg.view ? s_r.rld[k] : s_r.cmp[k]; // see (R10)
					end
				end
			end
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = 1'b0;
		s_nxt.bus = pcr_pkg::PCR_IDLE;

		if (s_r.run) begin
			s_nxt.cnt = s_r.cnt + 16'h0001;
		end

		// Configuration write; bit 4 has no storage
		if (cfg_wr) begin // see (R4)
			s_nxt.cfg.view = wb_dat_i[pcr_pkg::CFG_VIEW];
			s_nxt.cfg.ovie = wb_dat_i[pcr_pkg::CFG_OVIE];
			s_nxt.cfg.ovf = wb_dat_i[pcr_pkg::CFG_OVF]; // see (R3)
			s_nxt.cfg.wrld = wb_dat_i[pcr_pkg::CFG_WRLD];
			s_nxt.cfg.len = wb_dat_i[pcr_pkg::CFG_LEN_LO +: pcr_pkg::LEN_W];
		end
		if (clr_wr && wb_dat_i[pcr_pkg::IRQ_OVF]) begin
			s_nxt.cfg.ovf = 1'b0; // see (R3)
		end
		if (clr_wr && wb_dat_i[pcr_pkg::IRQ_CTR]) begin
			s_nxt.ctr_ovf = 1'b0;
		end
		// Hardware set placed last so it wins over any clear
		if (cyc_wrap) begin
			s_nxt.cfg.ovf = 1'b1; // see (R2) see (R11)
		end
		if (ctr_wrap) begin
			s_nxt.ctr_ovf = 1'b1;
		end

		if (req && wb_we_i && wb_sel_i[0]) begin
			case (wb_adr_i)
				pcr_pkg::ADR_CTRL: begin
					s_nxt.run = wb_dat_i[pcr_pkg::CTRL_RUN];
					s_nxt.wide = wb_dat_i[pcr_pkg::CTRL_WIDE_LO +: pcr_pkg::NUM_CH];
				end
				pcr_pkg::ADR_IEN: begin
					s_nxt.cfg.ovie = wb_dat_i[pcr_pkg::IRQ_OVF];
					s_nxt.ctr_ien = wb_dat_i[pcr_pkg::IRQ_CTR];
				end
				default: begin
				end
			endcase
		end

		for (int k = 0; k < pcr_pkg::NUM_CH; k++) begin
			// Software write through the selected view
			if (ch_wr[k]) begin
				if (s_r.cfg.view) begin // see (R10)
					s_nxt.rld[k] = merge16(s_r.rld[k], wb_dat_i, wb_sel_i);
				end else begin
					s_nxt.cmp[k] = merge16(s_r.cmp[k], wb_dat_i, wb_sel_i);
				end
			end
			// Reload taken after the write so a wrap edge always loads the shadow
			if (ch_rld[k]) begin // see (R5) see (R6) see (R7)
				s_nxt.cmp[k] = s_r.rld[k];
			end
			// 16-bit channels compare the whole counter
			if (s_r.wide[k]) begin // see (R9)
				s_nxt.pwm[k] = s_r.cnt < s_r.cmp[k];
			end else begin // see (R8)
				s_nxt.pwm[k] = (s_r.cnt & len_mask) < (s_r.cmp[k] & len_mask);
			end
		end

		s_nxt.irq = (s_r.cfg.ovie && s_r.cfg.ovf) || (s_r.ctr_ien && s_r.ctr_ovf); // see (R1)

		if (req) begin
			s_nxt.ack = 1'b1;
			s_nxt.bus = pcr_pkg::PCR_ACK;
			if (wb_we_i) begin
				s_nxt.dat = 32'h00000000;
			end else begin
				s_nxt.dat = rd_word;
			end
		end

		if (rst_i) begin
			s_nxt = '0;
			s_nxt.cfg = pcr_pkg::pcr_cfg_t'({pcr_pkg::CFG_RESET[7:5], pcr_pkg::CFG_RESET[3:0]});
			s_nxt.bus = pcr_pkg::PCR_IDLE;
			s_nxt.cmp = {pcr_pkg::NUM_CH{pcr_pkg::CMP_RESET}};
			s_nxt.rld = {pcr_pkg::NUM_CH{pcr_pkg::CMP_RESET}};
		end
	end

	always_ff @(posedge clk_i) begin
		s_r <= s_nxt;
	end

	assign wb_dat_o = s_r.dat;
	assign wb_ack_o = s_r.ack;
	assign irq_o = s_r.irq;
	assign pwm_o = s_r.pwm;

	// Checks on the logic above
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_read_cfg;
		req && !wb_we_i && (wb_adr_i == pcr_pkg::ADR_CFG);
	endsequence

	sequence s_read_ch0_view;
		req && !wb_we_i && ch_hit(wb_adr_i, 0) && s_r.cfg.view;
	endsequence

	sequence s_write_ch0_view;
		ch_wr[0] && s_r.cfg.view && !ch_rld[0];
	endsequence

	sequence s_write_ch0_full;
		ch_wr[0] && !s_r.cfg.view && !ch_rld[0] && (wb_sel_i == 4'hF);
	endsequence

	a_irq_masked: assert property (!(s_r.cfg.ovie && s_r.cfg.ovf) && // see (R1)
		!(s_r.ctr_ien && s_r.ctr_ovf) |=> !irq_o) else $error("irq raised with no enabled flag");

	a_irq_raised: assert property (s_r.cfg.ovie && s_r.cfg.ovf |=> irq_o) // see (R1)
		else $error("enabled cycle flag gave no irq");

	a_irq_wrap: assert property (s_r.ctr_ien && s_r.ctr_ovf |=> irq_o) // see (R1)
		else $error("enabled wrap flag gave no irq");

	a_cycle_flag_set: assert property (cyc_wrap |=> s_r.cfg.ovf) // see (R2)
		else $error("cycle wrap did not set flag");

	a_flag_quiet: assert property (!s_r.cfg.ovf && !cyc_wrap && !sw_ovf_set // see (R2)
		|=> !s_r.cfg.ovf) else $error("cycle flag set with no overflow");

	a_flag_sticky: assert property (s_r.cfg.ovf && !sw_ovf_clr |=> s_r.cfg.ovf) // see (R3)
		else $error("cycle flag dropped without software");

	a_sw_set: assert property (sw_ovf_set |=> s_r.cfg.ovf) // see (R3)
		else $error("software set of cycle flag lost");

	a_sw_clear: assert property (clr_wr && wb_dat_i[pcr_pkg::IRQ_OVF] && !cyc_wrap // see (R3)
		|=> !s_r.cfg.ovf) else $error("software clear of cycle flag lost");

	a_unused_bit_zero: assert property (s_read_cfg // see (R4)
		|=> wb_ack_o && !wb_dat_o[pcr_pkg::CFG_UNUSED]) else $error("unused config bit read as one");

	a_reload_ch0: assert property (ch_rld[0] |=> s_r.cmp[0] == $past(s_r.rld[0])) // see (R5)
		else $error("reload not copied on wrap, channel 0");

	a_reload_ch1: assert property (ch_rld[1] |=> s_r.cmp[1] == $past(s_r.rld[1])) // see (R5)
		else $error("reload not copied on wrap, channel 1");

	a_reload_ch2: assert property (ch_rld[2] |=> s_r.cmp[2] == $past(s_r.rld[2])) // see (R5)
		else $error("reload not copied on wrap, channel 2");

	a_scope_ch0: assert property (ctr_wrap && !s_r.wide[0] && !ch_wr[0] // see (R6)
		|=> $stable(s_r.cmp[0])) else $error("reload touched narrow channel 0");

	a_scope_ch1: assert property (ctr_wrap && !s_r.wide[1] && !ch_wr[1] // see (R6)
		|=> $stable(s_r.cmp[1])) else $error("reload touched narrow channel 1");

	a_scope_ch2: assert property (ctr_wrap && !s_r.wide[2] && !ch_wr[2] // see (R6)
		|=> $stable(s_r.cmp[2])) else $error("reload touched narrow channel 2");

	a_reload_off: assert property (!s_r.cfg.wrld && !ch_wr[0] |=> $stable(s_r.cmp[0])) // see (R7)
		else $error("compare 0 changed without write");

	a_reload_off_ch1: assert property (!s_r.cfg.wrld && !ch_wr[1] // see (R7)
		|=> $stable(s_r.cmp[1])) else $error("compare 1 changed without write");

	a_reload_off_ch2: assert property (!s_r.cfg.wrld && !ch_wr[2] // see (R7)
		|=> $stable(s_r.cmp[2])) else $error("compare 2 changed without write");

	a_cycle_length: assert property (cyc_wrap && !cfg_wr // see (R8)
		|=> (s_r.cnt & cycle_mask(s_r.cfg.len)) == 16'h0000) else $error("cycle wrap at wrong bit");

	a_narrow_ch0: assert property (!s_r.wide[0] |=> pwm_o[0] == // see (R8)
		(($past(s_r.cnt) & $past(len_mask)) < ($past(s_r.cmp[0]) & $past(len_mask))))
		else $error("narrow channel 0 used wrong length");

	a_narrow_ch1: assert property (!s_r.wide[1] |=> pwm_o[1] == // see (R8)
		(($past(s_r.cnt) & $past(len_mask)) < ($past(s_r.cmp[1]) & $past(len_mask))))
		else $error("narrow channel 1 used wrong length");

	a_wide_full: assert property (s_r.wide[0] // see (R9)
		|=> pwm_o[0] == ($past(s_r.cnt) < $past(s_r.cmp[0]))) else $error("wide channel used short cycle");

	a_wide_full_ch1: assert property (s_r.wide[1] // see (R9)
		|=> pwm_o[1] == ($past(s_r.cnt) < $past(s_r.cmp[1]))) else $error("wide channel 1 short cycle");

	a_view_read: assert property (s_read_ch0_view // see (R10)
		|=> wb_dat_o[15:0] == $past(s_r.rld[0])) else $error("view select read wrong register");

	a_view_read_ch1: assert property (req && !wb_we_i && ch_hit(wb_adr_i, 1) && s_r.cfg.view // see (R10)
		|=> wb_dat_o[15:0] == $past(s_r.rld[1])) else $error("view select read wrong register 1");

	a_cmp_read: assert property (req && !wb_we_i && ch_hit(wb_adr_i, 0) && !s_r.cfg.view // see (R10)
		|=> wb_dat_o[15:0] == $past(s_r.cmp[0])) else $error("normal view read wrong register");

	a_view_write: assert property (s_write_ch0_view |=> $stable(s_r.cmp[0])) // see (R10)
		else $error("reload view write reached compare");

	a_cmp_write: assert property (s_write_ch0_full // see (R10)
		|=> s_r.cmp[0] == $past(wb_dat_i[15:0])) else $error("compare write lost");

	a_upper_zero: assert property (s_read_ch0_view |=> wb_dat_o[31:16] == 16'h0000) // see (R10)
		else $error("channel read upper half not zero");

	a_set_wins: assert property (cyc_wrap && sw_ovf_clr |=> s_r.cfg.ovf) // see (R11)
		else $error("clear beat hardware set");

	a_ack_next: assert property (req |=> wb_ack_o)
		else $error("request got no ack");

	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack stood longer than one cycle");

	a_write_data_zero: assert property (req && wb_we_i |=> wb_dat_o == 32'h00000000)
		else $error("write cycle returned data");
endmodule
`default_nettype wire

/* tb/pcr_top_tb.sv */
// Self-checking bench for the PWM cycle length, overflow flag and reload block.
// Assumes pcr_top with a classic Wishbone slave, one 50 MHz clock, sync reset.
`default_nettype none
module pcr_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i;
	logic rst_i;
	logic wb_cyc_i;
	logic wb_stb_i;
	logic wb_we_i;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic irq_o;
	logic [pcr_pkg::NUM_CH-1:0] pwm;
	int bad_count;
	int cmp_count;
	localparam logic [7:0] ADR_CH1 = pcr_pkg::ADR_CH0 + pcr_pkg::ADR_CH_STEP;

	pcr_top pcr_top_i (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.irq_o(irq_o),
		.pwm_o(pwm)
	);

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	task automatic finish_test();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			bad_count++;
		end
	endtask

	// One classic cycle; request held until ack is sampled at a rising edge
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		chk("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(name, exp, q);
	endtask

	task automatic irq_chk(input logic exp);
		repeat (3) @(posedge clk_i);
		chk("irq_o", {31'h0, exp}, {31'h0, irq_o});
	endtask

	task automatic t_reset();
		rd_chk("cfg", pcr_pkg::ADR_CFG, 32'h0);
		irq_chk(1'b0);
	endtask

	task automatic t_unused();
		wr(pcr_pkg::ADR_CFG, 32'h17);
		rd_chk("cfg", pcr_pkg::ADR_CFG, 32'h07);
		rd_chk("unmapped", 8'h40, 32'h0);
	endtask

	// Code 001 must not flag at bit 8, only at bit 9
	task automatic t_cycle();
		logic [31:0] q;
		int n;
		wr(pcr_pkg::ADR_CFG, 32'h01);
		wr(pcr_pkg::ADR_CTRL, 32'h11);
		n = 0;
		do begin
			wb(1'b0, pcr_pkg::ADR_CNT, 32'h0, q);
			n++;
		end while (q < 32'h100 && n < 400);
		rd_chk("istat", pcr_pkg::ADR_ISTAT, 32'h0);
		do begin
			wb(1'b0, pcr_pkg::ADR_CNT, 32'h0, q);
			n++;
		end while (q < 32'h200 && n < 800);
		rd_chk("istat", pcr_pkg::ADR_ISTAT, 32'h1);
	endtask

	task automatic t_irq();
		irq_chk(1'b0);
		wr(pcr_pkg::ADR_CFG, 32'h61);
		irq_chk(1'b1);
		rd_chk("cfg", pcr_pkg::ADR_CFG, 32'h61);
		wr(pcr_pkg::ADR_ICLR, 32'h1);
		rd_chk("cfg", pcr_pkg::ADR_CFG, 32'h41);
		irq_chk(1'b0);
		wr(pcr_pkg::ADR_CFG, 32'h21);
		rd_chk("cfg", pcr_pkg::ADR_CFG, 32'h21);
	endtask

	// Channel 0 is wide, channel 1 narrow; one counter wrap with reload on
	task automatic t_reload();
		logic [31:0] q;
		logic [31:0] p;
		int n;
		wr(pcr_pkg::ADR_CFG, 32'h01);
		wr(pcr_pkg::ADR_CH0, 32'h1234);
		wr(ADR_CH1, 32'h0055);
		wr(pcr_pkg::ADR_CFG, 32'h81);
		wr(pcr_pkg::ADR_CH0, 32'hABCD);
		wr(ADR_CH1, 32'h0077);
		rd_chk("rld0", pcr_pkg::ADR_CH0, 32'hABCD);
		wr(pcr_pkg::ADR_CFG, 32'h01);
		rd_chk("cmp0", pcr_pkg::ADR_CH0, 32'h1234);
		rd_chk("cmp1", ADR_CH1, 32'h0055);
		wr(pcr_pkg::ADR_CFG, 32'h09);
		wb(1'b0, pcr_pkg::ADR_CNT, 32'h0, q);
		n = 0;
		do begin
			p = q;
			wb(1'b0, pcr_pkg::ADR_CNT, 32'h0, q);
			n++;
		end while (q >= p && n < 30000);
		rd_chk("cmp0", pcr_pkg::ADR_CH0, 32'hABCD);
		rd_chk("cmp1", ADR_CH1, 32'h0055);
		rd_chk("istat", pcr_pkg::ADR_ISTAT, 32'h3);
		// Stop the counter so both outputs settle on one count
		wr(pcr_pkg::ADR_CTRL, 32'h10);
		wb(1'b0, pcr_pkg::ADR_CNT, 32'h0, q);
		repeat (2) @(posedge clk_i);
		chk("pwm0", {31'h0, q[15:0] < 16'hABCD}, {31'h0, pwm[0]});
		chk("pwm1", {31'h0, q[8:0] < 9'h055}, {31'h0, pwm[1]});
	endtask

	initial begin
		bad_count = 0;
		cmp_count = 0;
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_unused();
		t_cycle();
		t_irq();
		t_reload();
		finish_test();
	end

	// Tests need about 70000 cycles, mostly the one full counter wrap
	initial begin
		repeat (95000) @(posedge clk_i);
		$display("[ERR] watchdog expected done seen hang");
		bad_count++;
		finish_test();
	end
endmodule
`default_nettype wire
